// File: design/circ_addr_pkg.sv
// Package for the circular-buffer address block: register map, field layout, widths.
// Assumes a 32-bit APB master and a 16-bit address generator on the same clock.
package circ_addr_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 16;
  localparam int PTR_SEL_W = 4;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_X_START = 12'h004;
  localparam logic [11:0] OFS_X_END = 12'h008;
  localparam logic [11:0] OFS_Y_START = 12'h00c;
  localparam logic [11:0] OFS_Y_END = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  // ==========================================================
  // Control field layout and reset values
  localparam int X_SEL_LSB = 0;
  localparam int Y_SEL_LSB = 4;
  localparam int X_EN_BIT = 15;
  localparam int Y_EN_BIT = 14;
  localparam logic [3:0] SEL_DISABLED = 4'hf;
  localparam logic [15:0] CONTROL_RESET = 16'h00ff;
  localparam logic [15:0] BOUND_RESET = 16'h0000;
  // Byte step of one word access
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // Request from the core address generator
  typedef struct packed {
    logic valid;
    logic [3:0] reg_sel;
    logic [15:0] ea;
    logic decrement;
  } ea_req_t;

  // Adjusted answer
  typedef struct packed {
    logic valid;
    logic [15:0] ea;
    logic wrapped;
  } ea_rsp_t;
endpackage

// File: design/modulo_wrap.sv
// One modulo address unit: checks an effective address against a buffer window.
// Assumes combinational use by the top, which registers the result.
`timescale 1ns/1ps
module modulo_wrap
  import circ_addr_pkg::*;
#(
  parameter bit WORD_ONLY = 1'b0
)(
  input wire logic enable,
  input wire logic [3:0] ptrSel,
  input wire logic [15:0] bufStart,
  input wire logic [15:0] bufEnd,
  input wire ea_req_t req,
  output ea_rsp_t rsp
);
  logic [15:0] ea;
  logic [15:0] lo;
  logic [15:0] hi;
  logic hit;
  always_comb begin
    // Word-only space forces the low bit clear on every address
    ea = WORD_ONLY ? {req.ea[15:1], 1'b0} : req.ea;
    lo = WORD_ONLY ? {bufStart[15:1], 1'b0} : bufStart;
    hi = WORD_ONLY ? {bufEnd[15:1], 1'b0} : bufEnd;
    // Only the selected pointer is steered, and select 15 means off
    hit = enable && (ptrSel != SEL_DISABLED) && (req.reg_sel == ptrSel);
    rsp.valid = req.valid;
    rsp.ea = ea;
    rsp.wrapped = 1'b0;
    // Upper bound checked when incrementing, lower bound when decrementing; both bounds lie inside the window
    if (hit && !req.decrement && (ea > hi)) begin
      rsp.ea = lo;
      rsp.wrapped = 1'b1;
    end else if (hit && req.decrement && (ea < lo)) begin
      rsp.ea = hi;
      rsp.wrapped = 1'b1;
    end
  end
endmodule

// File: design/circular_buffer_addressing.sv
// Circular-buffer address generation with an APB register file.
// Assumes the core address generators sit on sys_clk and present one EA per port per cycle.
`timescale 1ns/1ps
module circular_buffer_addressing
  import circ_addr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ea_req_t xRdReq,
  input wire ea_req_t xWrReq,
  input wire ea_req_t yReq,
  output ea_rsp_t xRdRsp,
  output ea_rsp_t xWrRsp,
  output ea_rsp_t yRsp
);
  // ==========================================================
  // Register file
  logic [15:0] circularAddrControl;
  logic [15:0] xBufferStart;
  logic [15:0] xBufferEnd;
  logic [15:0] yBufferStart;
  logic [15:0] yBufferEnd;
  logic [2:0] wrapSeen;
  logic setup;
  logic wrAccess;
  logic rdAccess;
  logic mapped;

  assign setup = psel && !penable;
  assign wrAccess = psel && penable && pwrite && pready;
  assign rdAccess = setup && !pwrite;

  always_comb begin
    if (paddr == OFS_CONTROL) begin
      mapped = 1'b1;
    end else if (paddr == OFS_X_START) begin
      mapped = 1'b1;
    end else if (paddr == OFS_X_END) begin
      mapped = 1'b1;
    end else if (paddr == OFS_Y_START) begin
      mapped = 1'b1;
    end else if (paddr == OFS_Y_END) begin
      mapped = 1'b1;
    end else if (paddr == OFS_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // No wait state: ready rises in the first access cycle after setup
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !mapped;
    end
  end

  // Write path; unmapped writes are dropped and flagged by pslverr
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      circularAddrControl <= CONTROL_RESET;
      xBufferStart <= BOUND_RESET;
      xBufferEnd <= BOUND_RESET;
      yBufferStart <= BOUND_RESET;
      yBufferEnd <= BOUND_RESET;
    end else if (wrAccess) begin
      if (paddr == OFS_CONTROL) begin
        circularAddrControl <= pwdata[15:0];
      end else if (paddr == OFS_X_START) begin
        xBufferStart <= pwdata[15:0];
      end else if (paddr == OFS_X_END) begin
        xBufferEnd <= pwdata[15:0];
      end else if (paddr == OFS_Y_START) begin
        yBufferStart <= pwdata[15:0];
      end else if (paddr == OFS_Y_END) begin
        yBufferEnd <= pwdata[15:0];
      end
    end
  end

  // Read data is loaded at setup so it is stable during the access cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdAccess) begin
      if (paddr == OFS_CONTROL) begin
        prdata <= {16'h0000, circularAddrControl};
      end else if (paddr == OFS_X_START) begin
        prdata <= {16'h0000, xBufferStart};
      end else if (paddr == OFS_X_END) begin
        prdata <= {16'h0000, xBufferEnd};
      end else if (paddr == OFS_Y_START) begin
        prdata <= {16'h0000, yBufferStart};
      end else if (paddr == OFS_Y_END) begin
        prdata <= {16'h0000, yBufferEnd};
      end else if (paddr == OFS_STATUS) begin
        prdata <= {29'h0000_0000, wrapSeen};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Address units
  logic xEnable;
  logic yEnable;
  logic [3:0] xSel;
  logic [3:0] ySel;
  ea_rsp_t nextXRd;
  ea_rsp_t nextXWr;
  ea_rsp_t nextY;

  assign xSel = circularAddrControl[X_SEL_LSB +: PTR_SEL_W];
  assign ySel = circularAddrControl[Y_SEL_LSB +: PTR_SEL_W];
  assign xEnable = circularAddrControl[X_EN_BIT];
  assign yEnable = circularAddrControl[Y_EN_BIT];

  // X read and write generators share one buffer; program-space pointers
  // come through the same X ports, so they wrap identically
  modulo_wrap #(.WORD_ONLY(1'b0)) xRdUnit (
    .enable(xEnable),
    .ptrSel(xSel),
    .bufStart(xBufferStart),
    .bufEnd(xBufferEnd),
    .req(xRdReq),
    .rsp(nextXRd)
  );

  modulo_wrap #(.WORD_ONLY(1'b0)) xWrUnit (
    .enable(xEnable),
    .ptrSel(xSel),
    .bufStart(xBufferStart),
    .bufEnd(xBufferEnd),
    .req(xWrReq),
    .rsp(nextXWr)
  );

  modulo_wrap #(.WORD_ONLY(1'b1)) yUnit (
    .enable(yEnable),
    .ptrSel(ySel),
    .bufStart(yBufferStart),
    .bufEnd(yBufferEnd),
    .req(yReq),
    .rsp(nextY)
  );

  // Full 16-bit compare covers a 64 Kbyte window; no register for W14/W15
  // is refused, software must avoid them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      xRdRsp <= '0;
      xWrRsp <= '0;
      yRsp <= '0;
    end else begin
      xRdRsp <= nextXRd;
      xWrRsp <= nextXWr;
      yRsp <= nextY;
    end
  end

  // Sticky wrap seen: set wins over a clear written to the status word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrapSeen <= 3'h0;
    end else begin
      wrapSeen <= (wrAccess && paddr == OFS_STATUS) ? (wrapSeen & ~pwdata[2:0]) : wrapSeen;
      if (nextXRd.valid && nextXRd.wrapped) wrapSeen[0] <= 1'b1;
      if (nextXWr.valid && nextXWr.wrapped) wrapSeen[1] <= 1'b1;
      if (nextY.valid && nextY.wrapped) wrapSeen[2] <= 1'b1;
    end
  end
endmodule

// File: testbench/circ_addr_properties.sv
// Checker: APB handshake, pass-through and word-alignment timing.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/1ps
module circ_addr_properties
  import circ_addr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire ea_req_t xRdReq,
  input wire ea_req_t xWrReq,
  input wire ea_req_t yReq,
  input wire ea_rsp_t xRdRsp,
  input wire ea_rsp_t xWrRsp,
  input wire ea_rsp_t yRsp
);
  // ==========================
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  chk_xrd_pass: assert property (xRdReq.valid && xRdReq.reg_sel == SEL_DISABLED
    |=> xRdRsp.valid && xRdRsp.ea == $past(xRdReq.ea) && !xRdRsp.wrapped) else $error("x read altered");
  chk_xwr_pass: assert property (xWrReq.valid && xWrReq.reg_sel == SEL_DISABLED
    |=> xWrRsp.valid && xWrRsp.ea == $past(xWrReq.ea) && !xWrRsp.wrapped) else $error("x write altered");
  chk_y_pass: assert property (yReq.valid && yReq.reg_sel == SEL_DISABLED
    |=> yRsp.ea == {$past(yReq.ea[15:1]), 1'h0} && !yRsp.wrapped) else $error("y altered");
  chk_y_word: assert property (yRsp.valid |-> !yRsp.ea[0])
    else $error("y odd address");
  chk_xrd_wrap_moves: assert property (xRdRsp.wrapped |-> xRdRsp.ea != $past(xRdReq.ea))
    else $error("wrap kept address");
endmodule

bind circular_buffer_addressing circ_addr_properties circ_addr_properties_i (.sys_clk(sys_clk), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .xRdReq(xRdReq), .xWrReq(xWrReq),
  .yReq(yReq), .xRdRsp(xRdRsp), .xWrRsp(xWrRsp), .yRsp(yRsp));

// File: testbench/core_agu_model.sv
// Core address generator model: one pointer stepping a word per request.
// Assumes the bench loads it and pulses go every other cycle.
`timescale 1ns/1ps
module core_agu_model
  import circ_addr_pkg::*;
(
  input wire logic clk,
  input wire logic load,
  input wire logic [15:0] seed,
  input wire logic go,
  input wire logic down,
  input wire logic [3:0] sel,
  input wire ea_rsp_t rsp,
  output ea_req_t req
);
  logic [15:0] ptr;
  // ==========================
  // Pointer
  // Answer written back, so a wrap really moves the pointer
  always_ff @(posedge clk) begin
    if (load) begin
      ptr <= seed;
    end else if (rsp.valid) begin
      ptr <= rsp.ea;
    end
  end
  // One direction per run unless the buffer is a power of two
  assign req = '{go, sel, down ? ptr - WORD_STEP : ptr + WORD_STEP, down};
endmodule

// File: testbench/circular_buffer_addressing_tb_top.sv
// Bench: APB registers and wrap behaviour of the three address ports.
// Assumes the package and the core model are compiled first.
`timescale 1ns/1ps
module circular_buffer_addressing_tb_top
  import circ_addr_pkg::*;
;
  // ==========================
  // Signals
  logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic load = 1'h0, go = 1'h0, down = 1'h0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [15:0] seed = '0;
  logic [3:0] xSel = 4'hf;
  ea_req_t xRdReq, xWrReq = '0, yReq = '0;
  ea_rsp_t xRdRsp, xWrRsp, yRsp;
  int n_fail = 0, n_compared = 0;
  circular_buffer_addressing circular_buffer_addressing_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xRdReq(xRdReq), .xWrReq(xWrReq), .yReq(yReq), .xRdRsp(xRdRsp), .xWrRsp(xWrRsp),
    .yRsp(yRsp));
  core_agu_model core_agu_model_i (.clk(sys_clk), .load(load), .seed(seed), .go(go), .down(down),
    .sel(xSel), .rsp(xRdRsp), .req(xRdReq));
  initial forever #2 sys_clk = ~sys_clk;
  // ==========================
  // Tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Starts and ends just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x, input logic e);
    int n;
    n = 0;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'h1 && n < 20);
    if (!w) check(prdata, x);
    if (!w) check(pslverr, e);
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      n_fail++;
      $display("unexpected at %0t: no pready", $time);
      tally_and_finish();
    end
    // One idle edge between transfers, so the next call never re-drives psel in this time step
    @(posedge sys_clk);
  endtask
  task step(input logic p, input logic [3:0] s, input logic [15:0] a, input logic dn, input logic [17:0] x);
    if (p) yReq <= '{1'h1, s, a, dn};
    else xWrReq <= '{1'h1, s, a, dn};
    @(posedge sys_clk);
    yReq <= '0; xWrReq <= '0;
    @(negedge sys_clk);
    check(p ? yRsp : xWrRsp, x);
    @(posedge sys_clk);
  endtask
  task xstep(input logic dn, input logic [17:0] x);
    go <= 1'h1; down <= dn;
    @(posedge sys_clk);
    go <= 1'h0;
    @(negedge sys_clk);
    check(xRdRsp, x);
    @(posedge sys_clk);
  endtask
  task ld(input logic [3:0] s, input logic [15:0] v);
    xSel <= s; seed <= v; load <= 1'h1;
    @(posedge sys_clk);
    load <= 1'h0;
  endtask
  // ==========================
  // Scenarios
  task t_regs;
    apb(1'h0, OFS_CONTROL, '0, CONTROL_RESET, 1'h0);
    apb(1'h0, OFS_X_END, '0, BOUND_RESET, 1'h0);
    apb(1'h1, OFS_Y_END, 32'hffff1234, '0, 1'h0);
    apb(1'h0, OFS_Y_END, '0, 32'h1234, 1'h0);
    apb(1'h0, 12'h018, '0, '0, 1'h1);
    $display("regs done");
  endtask
  task t_xwrap;
    apb(1'h1, OFS_X_START, 32'h1000, '0, 1'h0);
    apb(1'h1, OFS_X_END, 32'h100e, '0, 1'h0);
    apb(1'h1, OFS_CONTROL, 32'h80f3, '0, 1'h0);
    ld(4'h3, 16'h100c);
    xstep(1'h0, {1'h1, 16'h100e, 1'h0});
    xstep(1'h0, {1'h1, 16'h1000, 1'h1});
    xstep(1'h1, {1'h1, 16'h100e, 1'h1});
    step(1'h0, 4'h4, 16'h1010, 1'h0, {1'h1, 16'h1010, 1'h0});
    step(1'h0, 4'h3, 16'h1010, 1'h0, {1'h1, 16'h1000, 1'h1});
    apb(1'h0, OFS_STATUS, '0, 32'h3, 1'h0);
    apb(1'h1, OFS_STATUS, 32'h7, '0, 1'h0);
    apb(1'h0, OFS_STATUS, '0, '0, 1'h0);
    $display("x wrap done");
  endtask
  task t_yword;
    apb(1'h1, OFS_Y_START, 32'h2000, '0, 1'h0);
    apb(1'h1, OFS_Y_END, 32'h200f, '0, 1'h0);
    apb(1'h1, OFS_CONTROL, 32'h4053, '0, 1'h0);
    step(1'h1, 4'h5, 16'h2011, 1'h0, {1'h1, 16'h2000, 1'h1});
    step(1'h1, 4'h5, 16'h200f, 1'h0, {1'h1, 16'h200e, 1'h0});
    step(1'h1, 4'h5, 16'h1ffe, 1'h1, {1'h1, 16'h200e, 1'h1});
    step(1'h0, 4'h3, 16'h1010, 1'h0, {1'h1, 16'h1010, 1'h0});
    apb(1'h0, OFS_STATUS, '0, 32'h4, 1'h0);
    $display("y word done");
  endtask
  task t_off;
    apb(1'h1, OFS_CONTROL, 32'hc0ff, '0, 1'h0);
    ld(4'hf, 16'h100e);
    xstep(1'h0, {1'h1, 16'h1010, 1'h0});
    step(1'h0, 4'hf, 16'h1010, 1'h0, {1'h1, 16'h1010, 1'h0});
    step(1'h1, 4'hf, 16'h2011, 1'h0, {1'h1, 16'h2010, 1'h0});
    // Mid-run reset must bring back the reset control word, the X start bound and status
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    apb(1'h0, OFS_CONTROL, '0, CONTROL_RESET, 1'h0);
    apb(1'h0, OFS_X_START, '0, BOUND_RESET, 1'h0);
    apb(1'h0, OFS_STATUS, '0, '0, 1'h0);
    $display("select off done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    t_regs();
    t_xwrap();
    t_yword();
    t_off();
    tally_and_finish();
  end
endmodule
